// ==== hdl/gtr_pkg.sv ====
package gtr_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] GTR_IDX_COUNT = 12'h100;
  localparam logic [11:0] GTR_IDX_PERIOD = 12'h102;
  localparam logic [11:0] GTR_IDX_CTRL = 12'h104;
  localparam logic [11:0] GTR_IDX_IRQ = 12'h106;
  localparam logic [11:0] GTR_IDX_OSC = 12'h108;
  localparam logic [13:0] GTR_ADDR_COUNT = {GTR_IDX_COUNT, 2'b00};
  localparam logic [13:0] GTR_ADDR_PERIOD = {GTR_IDX_PERIOD, 2'b00};
  localparam logic [13:0] GTR_ADDR_CTRL = {GTR_IDX_CTRL, 2'b00};
  localparam logic [13:0] GTR_ADDR_IRQ = {GTR_IDX_IRQ, 2'b00};
  localparam logic [13:0] GTR_ADDR_OSC = {GTR_IDX_OSC, 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GTR_CTRL_EN = 15;
  localparam int GTR_CTRL_IDLE_STOP = 13;
  localparam int GTR_CTRL_GATE = 6;
  localparam int GTR_CTRL_PS_HI = 5;
  localparam int GTR_CTRL_PS_LO = 4;
  localparam int GTR_CTRL_SYNC = 2;
  localparam int GTR_CTRL_SRC = 1;
  localparam int GTR_IRQ_FLAG = 0;
  localparam int GTR_IRQ_EN = 1;
  localparam int GTR_OSC_LPEN = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GTR_RST_COUNT = 16'h0000;
  localparam logic [15:0] GTR_RST_PERIOD = 16'hFFFF;

  // ----------------------------------------------------------------
  // prescaler terminal counts and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] GTR_PS_TC_DIV1 = 8'h00;
  localparam logic [7:0] GTR_PS_TC_DIV8 = 8'h07;
  localparam logic [7:0] GTR_PS_TC_DIV64 = 8'h3F;
  localparam logic [7:0] GTR_PS_TC_DIV256 = 8'hFF;
  localparam logic [1:0] GTR_RESP_OKAY = 2'h0;
  localparam logic [1:0] GTR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GTR_PS_DIV1 = 2'b00,
    GTR_PS_DIV8 = 2'b01,
    GTR_PS_DIV64 = 2'b10,
    GTR_PS_DIV256 = 2'b11
  } gtr_ps_t;

endpackage : gtr_pkg

// ==== hdl/gtr_sync.sv ====
`timescale 1ns/1ns
module gtr_sync
  import gtr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic meta;
    logic stable;
  } gtr_sync_t;

  gtr_sync_t q;
  gtr_sync_t d;

  // two-stage capture; only the second stage leaves the module
  always_comb begin
    d = q;
    d.meta = din;
    d.stable = q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;

endmodule : gtr_sync

// ==== hdl/gtr_prescale.sv ====
`timescale 1ns/1ns
module gtr_prescale
  import gtr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic tick_out
);

  typedef struct packed {
    logic [7:0] cnt;
  } gtr_psc_t;

  gtr_psc_t q;
  gtr_psc_t d;
  logic [7:0] tc;

  // divide ratio decode
  always_comb begin
    case (gtr_ps_t'(sel))
      GTR_PS_DIV1: tc = GTR_PS_TC_DIV1;
      GTR_PS_DIV8: tc = GTR_PS_TC_DIV8;
      GTR_PS_DIV64: tc = GTR_PS_TC_DIV64;
      GTR_PS_DIV256: tc = GTR_PS_TC_DIV256;
      default: tc = GTR_PS_TC_DIV1;
    endcase
  end

  // count input ticks, emit one per terminal count
  always_comb begin
    d = q;
    if (clear) begin
      d.cnt = 8'h00;
    end else if (tick_in) begin
      if (q.cnt >= tc) begin
        d.cnt = 8'h00;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = tick_in && !clear && (q.cnt >= tc);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_psc_clear_zero: assert property (clear |=> q.cnt == 8'h00)
    else $error("prescaler not cleared");
  a_psc_div1_pass: assert property ((sel == 2'b00) && tick_in && !clear |-> tick_out)
    else $error("divide by one dropped a tick");

endmodule : gtr_prescale

// ==== hdl/gtr_timer.sv ====
`timescale 1ns/1ns
// Overview of operation
// - internal mode: count each instruction cycle to period, wrap to zero.
// - in idle with stop_in_idle set counting halts, resumes after idle.
// - synchronous counter: synchronised external rising edges count to period, wrap.
// - asynchronous counter: external rising edges count to period; stops in idle if set.
// - gated mode: instruction cycles count only while the gate pin is high.
// - prescaler divides the selected clock by 1, 8, 64 or 256.
// - prescaler cleared by count write, count_enable clearing, and reset.
// - with count_enable low the prescaler is not cleared.
// - control writes leave the count alone; only count writes change it.
// - in sleep only enabled asynchronous external counting continues, wrapping at period.
// - a period match during sleep can raise the interrupt request.
// - period match sets a sticky flag that requests an interrupt.
// - gated mode: gate falling edge sets the flag, count kept.
// - interrupt request passes only when period_irq_enable is set.
// - clock mode counts low-power oscillator rising edges to period, wraps.
// - low_power_osc_enable disables normal modes, enables carry-out wake event.
// - clock keeps running in sleep while the oscillator runs, if the sync bit is clear.
module gtr_timer
  import gtr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gate_clock_pin,
  input wire logic lp_osc_pin,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic irq_req,
  output logic wake_event
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic cnt_en;
    logic idle_stop;
    logic gate_en;
    logic [1:0] ps_sel;
    logic ext_sync;
    logic ext_src;
    logic flag;
    logic irq_en;
    logic lposc;
    logic pin_prev;
    logic lp_prev;
    logic wake;
    logic aw_held;
    logic [13:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gtr_state_t;

  gtr_state_t q;
  gtr_state_t d;

  logic pin_s;
  logic lp_s;
  logic run;
  logic normal_ok;
  logic ext_rise;
  logic raw_tick;
  logic inc;
  logic psc_clear;
  logic match;
  logic gate_fall;
  logic wr_go;
  logic wr_cnt;
  logic wr_per;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_osc;
  logic [15:0] ctrl_now;
  logic [15:0] ctrl_new;
  logic [15:0] count_q;

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : merge16

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  gtr_sync u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(gate_clock_pin),
    .dout(pin_s)
  );

  gtr_sync u_lp_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(lp_osc_pin),
    .dout(lp_s)
  );

  // ----------------------------------------------------------------
  // count source selection
  // ----------------------------------------------------------------
  // control word as software sees it
  always_comb begin
    ctrl_now = 16'h0000;
    ctrl_now[GTR_CTRL_EN] = q.cnt_en;
    ctrl_now[GTR_CTRL_IDLE_STOP] = q.idle_stop;
    ctrl_now[GTR_CTRL_GATE] = q.gate_en;
    ctrl_now[GTR_CTRL_PS_HI:GTR_CTRL_PS_LO] = q.ps_sel;
    ctrl_now[GTR_CTRL_SYNC] = q.ext_sync;
    ctrl_now[GTR_CTRL_SRC] = q.ext_src;
  end

  // write decode of the held address and data
  assign wr_go = q.aw_held && q.w_held && !q.bvalid;
  assign wr_cnt = wr_go && (q.awaddr == GTR_ADDR_COUNT);
  assign wr_per = wr_go && (q.awaddr == GTR_ADDR_PERIOD);
  assign wr_ctrl = wr_go && (q.awaddr == GTR_ADDR_CTRL);
  assign wr_irq = wr_go && (q.awaddr == GTR_ADDR_IRQ);
  assign wr_osc = wr_go && (q.awaddr == GTR_ADDR_OSC);
  assign ctrl_new = merge16(ctrl_now, q.wdata, q.wstrb);

  // enable, idle and sleep gating
  assign run = q.cnt_en
             && !(cpu_idle && q.idle_stop)
             && !(cpu_sleep && !(q.ext_src && !q.ext_sync));
  // low-power oscillator leaves only the clock mode alive
  assign normal_ok = !q.lposc || (q.ext_src && !q.gate_en);
  // rising edge of the selected external source, after synchronising
  assign ext_rise = q.lposc ? (lp_s && !q.lp_prev)
                            : (pin_s && !q.pin_prev);
  // per-cycle tick into the prescaler
  assign raw_tick = run && normal_ok && (q.ext_src ? ext_rise
                                                   : (!q.gate_en || pin_s));

  // prescaler clears only while the timer is enabled
  assign psc_clear = q.cnt_en && (wr_cnt || (wr_ctrl && !ctrl_new[GTR_CTRL_EN]));

  gtr_prescale u_psc (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(raw_tick),
    .clear(psc_clear),
    .sel(q.ps_sel),
    .tick_out(inc)
  );

  assign match = inc && (q.count == q.period);
  // end of accumulation in gated mode
  assign gate_fall = q.cnt_en && q.gate_en && !q.ext_src && q.pin_prev && !pin_s;
  assign count_q = q.count;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.pin_prev = pin_s;
    d.lp_prev = lp_s;
    // counter: software write wins over increment
    if (wr_cnt) begin
      d.count = merge16(q.count, q.wdata, q.wstrb);
    end else if (match) begin
      d.count = GTR_RST_COUNT;
    end else if (inc) begin
      d.count = q.count + 16'h0001;
    end
    // carry-out wake pulse in low-power oscillator mode
    d.wake = match && q.lposc;
    if (wr_per) begin
      d.period = merge16(q.period, q.wdata, q.wstrb);
    end
    // control write never touches the count
    if (wr_ctrl) begin
      d.cnt_en = ctrl_new[GTR_CTRL_EN];
      d.idle_stop = ctrl_new[GTR_CTRL_IDLE_STOP];
      d.gate_en = ctrl_new[GTR_CTRL_GATE];
      d.ps_sel = ctrl_new[GTR_CTRL_PS_HI:GTR_CTRL_PS_LO];
      d.ext_sync = ctrl_new[GTR_CTRL_SYNC];
      d.ext_src = ctrl_new[GTR_CTRL_SRC];
    end
    // sticky flag: hardware set wins over a software clear
    if (wr_irq) begin
      if (q.wstrb[0]) begin
        d.flag = q.wdata[GTR_IRQ_FLAG];
        d.irq_en = q.wdata[GTR_IRQ_EN];
      end
    end
    if (match || gate_fall) begin
      d.flag = 1'b1;
    end
    if (wr_osc && q.wstrb[0]) begin
      d.lposc = q.wdata[GTR_OSC_LPEN];
    end
    // write channels: capture address and data independently
    if (s_axi_awvalid && !q.aw_held) begin
      d.aw_held = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_held) begin
      d.w_held = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (wr_cnt || wr_per || wr_ctrl || wr_irq || wr_osc) ? GTR_RESP_OKAY
                                                                 : GTR_RESP_SLVERR;
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // read channel: one cycle to answer
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = GTR_RESP_OKAY;
      case (s_axi_araddr)
        GTR_ADDR_COUNT: d.rdata = {16'h0000, q.count};
        GTR_ADDR_PERIOD: d.rdata = {16'h0000, q.period};
        GTR_ADDR_CTRL: d.rdata = {16'h0000, ctrl_now};
        GTR_ADDR_IRQ: d.rdata = {30'h0, q.irq_en, q.flag};
        GTR_ADDR_OSC: d.rdata = {30'h0, q.lposc, 1'b0};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = GTR_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.count <= GTR_RST_COUNT;
      q.period <= GTR_RST_PERIOD;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready = !q.w_held;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq_req = q.flag && q.irq_en;
  assign wake_event = q.wake;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wrap_step;
    match && !wr_cnt;
  endsequence

  sequence s_gate_drop;
    (q.cnt_en && q.gate_en && !q.ext_src && pin_s)
      ##1 (q.cnt_en && q.gate_en && !q.ext_src && !pin_s && !wr_irq);
  endsequence

  sequence s_write_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence

  a_wrap_to_zero: assert property (s_wrap_step |=> (count_q == 16'h0000) && q.flag)
    else $error("count did not wrap at period");
  a_idle_halt: assert property (q.cnt_en && cpu_idle && q.idle_stop && !wr_cnt
                                |=> $stable(count_q))
    else $error("count moved in idle with stop set");
  a_sleep_halt: assert property (cpu_sleep && (!q.ext_src || q.ext_sync) && !wr_cnt
                                 |=> $stable(count_q))
    else $error("count moved in sleep without async source");
  a_ctrl_keeps: assert property (wr_ctrl && !inc |=> count_q == $past(count_q))
    else $error("control write changed the count");
  a_flag_sticky: assert property (q.flag && !wr_irq |=> q.flag)
    else $error("flag cleared without software");
  a_gate_fall: assert property (s_gate_drop |=> q.flag)
    else $error("gate falling edge missed");
  a_irq_pass: assert property ($rose(q.flag) && q.irq_en |-> irq_req)
    else $error("enabled interrupt not requested");
  a_irq_block: assert property (!q.irq_en |-> !irq_req)
    else $error("request without enable");
  a_lp_blocks: assert property (q.lposc && !q.ext_src && !wr_cnt |=> $stable(count_q))
    else $error("normal mode counted with oscillator enabled");
  a_gate_level: assert property (q.cnt_en && q.gate_en && !q.ext_src && !pin_s
                                 |-> !raw_tick)
    else $error("gated count without gate");
  a_write_resp: assert property (s_write_pair |=> ##1 s_axi_bvalid)
    else $error("write response late");

endmodule : gtr_timer

// ==== tb/gtr_pin_model.sv ====
`timescale 1ns/1ns
// far-side source of the external clock, gate and oscillator pins
module gtr_pin_model (
  input wire logic aclk,
  output logic gate_clock_pin,
  output logic lp_osc_pin
);
  // both pins rest low between bursts so no stray edge reaches the timer
  initial begin
    gate_clock_pin = 1'b0;
    lp_osc_pin = 1'b0;
  end

  // n rising edges on one pin, each level held for half cycles
  task automatic pulses(input logic osc, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      if (osc) lp_osc_pin <= 1'b1;
      else gate_clock_pin <= 1'b1;
      repeat (half) @(posedge aclk);
      lp_osc_pin <= 1'b0;
      gate_clock_pin <= 1'b0;
      repeat (half) @(posedge aclk);
    end
  endtask : pulses

  // gate high for k cycles, then dropped to end the accumulation
  task automatic hold_gate(input int k);
    gate_clock_pin <= 1'b1;
    repeat (k) @(posedge aclk);
    gate_clock_pin <= 1'b0;
  endtask : hold_gate
endmodule : gtr_pin_model

// ==== tb/gtr_tb_top.sv ====
`timescale 1ns/1ns
module gp_timer16_with_rtc_tb_top import gtr_pkg::*;;
  localparam logic [31:0] ctl_run = 32'h8000;
  localparam logic [31:0] ctl_idle_stop = 32'h2000;
  localparam logic [31:0] ctl_gate = 32'h40;
  localparam logic [31:0] ctl_sync = 32'h4;
  localparam logic [31:0] ctl_ext = 32'h2;
  logic aclk, aresetn;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic gate_clock_pin, lp_osc_pin, cpu_idle, cpu_sleep, irq_req, wake_event;
  logic [15:0] per, x;
  int err_total, n_compared, cyc, wake_n;
  integer seed;

  // --------------------------------------------------------------
  // design and far-side pin source
  // --------------------------------------------------------------
  gtr_timer gtr_timer_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gate_clock_pin(gate_clock_pin),
    .lp_osc_pin(lp_osc_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq_req(irq_req),
    .wake_event(wake_event)
  );
  gtr_pin_model gtr_pin_model_i (
    .aclk(aclk), .gate_clock_pin(gate_clock_pin), .lp_osc_pin(lp_osc_pin)
  );

  // 100 MHz clock
  always #5 aclk = ~aclk;

  // cycle ceiling and wake pulse tally
  always @(posedge aclk) begin
    cyc++;
    if (wake_event === 1'b1) wake_n++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // --------------------------------------------------------------
  // expectations, comparisons and bus cycles
  // --------------------------------------------------------------
  function automatic int div_of(input logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 8 : (s == 2'h2) ? 64 : 256;
  endfunction : div_of

  function automatic logic [15:0] after_edges(input logic [15:0] c, input logic [15:0] p,
                                              input int n);
    for (int i = 0; i < n; i++) c = (c == p) ? 16'h0 : c + 16'h1;
    return c;
  endfunction : after_edges

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] got);
    n_compared++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("mismatch %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_rng

  // one write: address and data offered together, held until each is taken
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("write answer", 32'h1, {31'h0, tb});
  endtask : wr

  // one read: result lands in rd_v and rsp
  task automatic rd(input logic [13:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("read answer", 32'h1, {31'h0, tr});
  endtask : rd

  task automatic results();
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'hB958302F;
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, cpu_idle, cpu_sleep} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
    s_axi_wstrb = 4'hF;
    {err_total, n_compared, cyc, wake_n} = 128'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset contents and an unmapped place
    rd(GTR_ADDR_PERIOD);
    chk("period reset", 32'hFFFF, rd_v);
    rd(14'h0430);
    chk("unmapped read", {30'h0, GTR_RESP_SLVERR}, {30'h0, rsp});
    wr(14'h0430, 32'h1234);
    chk("unmapped write", {30'h0, GTR_RESP_SLVERR}, {30'h0, rsp});
    // a control write leaves the count alone
    x = 16'($random(seed));
    wr(GTR_ADDR_COUNT, {16'h0, x});
    wr(GTR_ADDR_CTRL, 32'h30);
    rd(GTR_ADDR_COUNT);
    chk("count after control write", {16'h0, x}, rd_v);
    // every prescale setting over a fixed run
    for (int s = 0; s < 4; s++) begin
      wr(GTR_ADDR_COUNT, 32'h0);
      wr(GTR_ADDR_CTRL, ctl_run | (s << 4));
      repeat (600) @(posedge aclk);
      wr(GTR_ADDR_CTRL, 32'h0);
      rd(GTR_ADDR_COUNT);
      chk_rng("prescaled", 600 / div_of(s[1:0]) - 1, 614 / div_of(s[1:0]) + 1, rd_v);
    end
    // idle halts only with stop_in_idle set
    wr(GTR_ADDR_COUNT, 32'h0);
    cpu_idle <= 1'b1;
    wr(GTR_ADDR_CTRL, ctl_run | ctl_idle_stop);
    repeat (50) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    chk("count held in idle", 32'h0, rd_v);
    wr(GTR_ADDR_CTRL, ctl_run);
    repeat (100) @(posedge aclk);
    wr(GTR_ADDR_CTRL, 32'h0);
    cpu_idle <= 1'b0;
    rd(GTR_ADDR_COUNT);
    chk_rng("count through idle", 32'h64, 32'h74, rd_v);
    // external counting in sleep: asynchronous runs, synchronous waits
    cpu_sleep <= 1'b1;
    wr(GTR_ADDR_COUNT, 32'h0);
    wr(GTR_ADDR_CTRL, ctl_run | ctl_ext);
    gtr_pin_model_i.pulses(1'b0, 5, 3);
    repeat (8) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    chk("async in sleep", {16'h0, after_edges(16'h0, 16'hFFFF, 5)}, rd_v);
    wr(GTR_ADDR_CTRL, ctl_run | ctl_ext | ctl_sync);
    gtr_pin_model_i.pulses(1'b0, 5, 3);
    repeat (8) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    chk("sync in sleep", {16'h0, after_edges(16'h0, 16'hFFFF, 5)}, rd_v);
    cpu_sleep <= 1'b0;
    gtr_pin_model_i.pulses(1'b0, 5, 2);
    repeat (8) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    chk("sync awake", {16'h0, after_edges(16'h0, 16'hFFFF, 10)}, rd_v);
    // gated accumulation and its falling edge
    wr(GTR_ADDR_COUNT, 32'h0);
    wr(GTR_ADDR_IRQ, 32'h0);
    wr(GTR_ADDR_CTRL, ctl_run | ctl_gate);
    gtr_pin_model_i.hold_gate(40);
    repeat (8) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    x = rd_v[15:0];
    chk_rng("gated count", 32'h27, 32'h29, rd_v);
    rd(GTR_ADDR_IRQ);
    chk("gate fall flag", 32'h1, rd_v);
    rd(GTR_ADDR_COUNT);
    chk("count kept", {16'h0, x}, rd_v);
    // period match, sticky flag and request masking
    per = 16'h8 + 16'($random(seed) & 32'hF);
    wr(GTR_ADDR_PERIOD, {16'h0, per});
    wr(GTR_ADDR_COUNT, 32'h0);
    wr(GTR_ADDR_IRQ, 32'h0);
    wr(GTR_ADDR_CTRL, ctl_run);
    repeat (3 * per) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    chk_rng("count within period", 32'h0, {16'h0, per}, rd_v);
    wr(GTR_ADDR_CTRL, 32'h0);
    repeat (20) @(posedge aclk);
    rd(GTR_ADDR_IRQ);
    chk("flag held", 32'h1, rd_v);
    chk("request masked", 32'h0, {31'h0, irq_req});
    wr(GTR_ADDR_IRQ, 32'h3);
    @(negedge aclk);
    chk("request passed", 32'h1, {31'h0, irq_req});
    wr(GTR_ADDR_IRQ, 32'h2);
    @(negedge aclk);
    chk("request after clear", 32'h0, {31'h0, irq_req});
    // low-power oscillator clock through sleep
    wr(GTR_ADDR_COUNT, 32'h0);
    wr(GTR_ADDR_PERIOD, 32'h3);
    wr(GTR_ADDR_OSC, 32'h2);
    cpu_sleep <= 1'b1;
    wr(GTR_ADDR_CTRL, ctl_run | ctl_ext);
    gtr_pin_model_i.pulses(1'b1, 4, 5);
    repeat (8) @(posedge aclk);
    chk("wake pulses", 32'h1, wake_n);
    chk("request in sleep", 32'h1, {31'h0, irq_req});
    rd(GTR_ADDR_COUNT);
    chk("oscillator count", {16'h0, after_edges(16'h0, 16'h3, 4)}, rd_v);
    // internal source while the oscillator is enabled must not count
    cpu_sleep <= 1'b0;
    wr(GTR_ADDR_CTRL, ctl_run);
    repeat (20) @(posedge aclk);
    rd(GTR_ADDR_COUNT);
    chk("normal mode blocked", {16'h0, after_edges(16'h0, 16'h3, 4)}, rd_v);
    results();
  end
endmodule : gp_timer16_with_rtc_tb_top
